// [design/dpm_timer_cfg.svh]
// Purpose: constants for the input power management and safety timer register
// Assumes: register port gives 8-bit address, data, write and read strobes
// Notes:   offsets, field positions, reset value and threshold figures
`ifndef DPM_TIMER_CFG_SVH
`define DPM_TIMER_CFG_SVH

`define DPM_REG_ADDR       8'h0B
`define DPM_REG_RESET      8'h42
`define DPM_BIT_DISABLE    7
`define DPM_FLD_THR_HI     6
`define DPM_FLD_THR_LO     4
`define DPM_BIT_HALFRATE   3
`define DPM_FLD_TMR_HI     2
`define DPM_FLD_TMR_LO     1
`define DPM_BIT_UNUSED     0
`define DPM_THR_BASE_MV    16'd4200
`define DPM_THR_STEP_MV    16'd100
`define DPM_THR_RESET_MV   16'h11F8
`define DPM_GLOBAL_RESET_ADDR 8'h09
`define DPM_GLOBAL_RESET_BIT  7

`endif

// [design/dpm_timer_pkg.sv]
// Purpose: types for the input power management and safety timer register
// Assumes: nothing beyond the cfg header
// Notes:   timer limit codes and the register field layout
package dpm_timer_pkg;

  typedef enum logic [1:0] {
    TMR_30MIN   = 2'b00,
    TMR_3HOUR   = 2'b01,
    TMR_9HOUR   = 2'b10,
    TMR_DISABLE = 2'b11
  } timer_limit_e;

  // field layout of the register, msb first
  typedef struct packed {
    logic         inputPowerMgmtDisable;
    logic [2:0]   inputVoltagePowerMgmtThreshold;
    logic         timerHalfRateEnable;
    timer_limit_e safetyTimerLimitSelect;
    logic         unusedBit;
  } dpm_reg_s;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage

// [design/dpm_threshold_calc.sv]
// Purpose: turn the 3-bit threshold code into millivolts
// Assumes: code is stable register content
// Notes:   purely combinational, one place for the arithmetic
`timescale 1ns/1ps
`default_nettype none
`include "dpm_timer_cfg.svh"

module dpm_threshold_calc (
  input  wire logic [2:0]  code,
  output logic      [15:0] thresholdMv
);

  // each code bit weighs 400, 200, 100 mV
  assign thresholdMv = `DPM_THR_BASE_MV + {13'h0000, code} * `DPM_THR_STEP_MV;

endmodule
`default_nettype wire

// [design/charger_input_dpm_timer_regs.sv]
// Purpose: holds the input power management and safety timer register
// Assumes: register port strobes are one-cycle and synchronous to clock
// Notes:   decoded controls go to the analog loop and charge timer logic
`timescale 1ns/1ps
`default_nettype none
`include "dpm_timer_cfg.svh"

module charger_input_dpm_timer_regs
  import dpm_timer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic        ccCvPhase,
  input  wire logic        timerTick,
  output logic      [7:0]  regRdata,
  output logic             inputPowerMgmtEnable,
  output logic      [15:0] thresholdMvOut,
  output logic             timerStepEn,
  output logic             safetyTimerEnable,
  output timer_limit_e     safetyTimerLimitSelect
);

  dpm_reg_s   ctrl_reg;
  dpm_reg_s   ctrl_next;
  reg_req_s   req;
  logic [15:0] thrMv;
  logic        halfPhase_reg;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // address decode; global reset shares its address with other registers
  wire hitThis   = (req.addr == `DPM_REG_ADDR);
  wire wrThis    = req.wr && hitThis;
  wire globalRst = req.wr && (req.addr == `DPM_GLOBAL_RESET_ADDR)
                   && req.wdata[`DPM_GLOBAL_RESET_BIT];
  wire slowNow   = ctrl_reg.timerHalfRateEnable && !ccCvPhase;

  // global reset wins over a same-cycle write; bit 0 never stored
  always_comb begin
    ctrl_next = ctrl_reg;
    if (globalRst) begin
      ctrl_next = dpm_reg_s'(`DPM_REG_RESET);
    end else if (wrThis) begin
      ctrl_next = dpm_reg_s'({req.wdata[7:1], 1'b0});
    end
  end

  dpm_threshold_calc u_thr (
    .code        (ctrl_reg.inputVoltagePowerMgmtThreshold),
    .thresholdMv (thrMv)
  );

  // register storage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= dpm_reg_s'(`DPM_REG_RESET);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // limit code 11 is the only one that stops the safety timer
  function automatic logic limit_runs(input timer_limit_e code);
    limit_runs = (code != TMR_DISABLE);
  endfunction

  // a tick passes when not slowed, or as the second tick of a pair
  function automatic logic tick_passes(input logic slow,
                                       input logic phase);
    tick_passes = !slow || phase;
  endfunction

  // next values of the registered outputs
  logic [7:0]   regRdata_next;
  logic         inputPowerMgmtEnable_next;
  logic [15:0]  thresholdMvOut_next;
  logic         halfPhase_next;
  logic         timerStepEn_next;
  logic         safetyTimerEnable_next;
  timer_limit_e safetyTimerLimitSelect_next;

  // read data only while addressed, so an outer mux can simply or returns
  assign regRdata_next = (req.rd && hitThis) ? ctrl_reg : 8'h00;
  assign inputPowerMgmtEnable_next = !ctrl_reg.inputPowerMgmtDisable;
  assign thresholdMvOut_next = thrMv;

  // pair phase restarts on every unslowed tick, so after a mode change
  // the first slowed tick is the one dropped; costs at most one tick
  assign halfPhase_next   = timerTick ? (slowNow && !halfPhase_reg)
                                      : halfPhase_reg;
  assign timerStepEn_next = timerTick
                            && tick_passes(slowNow, halfPhase_reg);

  // code 11 stops the timer; the limit code is passed on unchanged
  assign safetyTimerEnable_next =
    limit_runs(ctrl_reg.safetyTimerLimitSelect);
  assign safetyTimerLimitSelect_next = ctrl_reg.safetyTimerLimitSelect;

  // registered outputs lag the register by one edge, so the analog side
  // sees a new setting two edges after the write strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regRdata               <= 8'h00;
      inputPowerMgmtEnable   <= 1'b1;
      thresholdMvOut         <= `DPM_THR_RESET_MV;
      timerStepEn            <= 1'b0;
      safetyTimerEnable      <= 1'b1;
      safetyTimerLimitSelect <= TMR_3HOUR;
      halfPhase_reg          <= 1'b0;
    end else begin
      regRdata               <= regRdata_next;
      inputPowerMgmtEnable   <= inputPowerMgmtEnable_next;
      thresholdMvOut         <= thresholdMvOut_next;
      timerStepEn            <= timerStepEn_next;
      safetyTimerEnable      <= safetyTimerEnable_next;
      safetyTimerLimitSelect <= safetyTimerLimitSelect_next;
      halfPhase_reg          <= halfPhase_next;
    end
  end

  // every check runs on the one clock and sleeps while reset is low;
  // past values at the first edge after release see the reset content
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // enable and threshold follow the stored fields one edge later
  AST_DPM_ENABLE: assert property (
    inputPowerMgmtEnable == !$past(ctrl_reg.inputPowerMgmtDisable))
    else $error("power management enable mismatch");
  AST_THRESH: assert property (
    thresholdMvOut == 16'd4200 + 16'd400 * $past(ctrl_reg[6])
      + 16'd200 * $past(ctrl_reg[5]) + 16'd100 * $past(ctrl_reg[4]))
    else $error("threshold weighting wrong");
  AST_THRESH_RANGE: assert property (
    thresholdMvOut >= 16'd4200 && thresholdMvOut <= 16'd4900)
    else $error("threshold out of range");

  // reset content gives regulation on at the middle threshold
  AST_RESET_VAL: assert property (
    $rose(rst_b) |-> ctrl_reg == `DPM_REG_RESET)
    else $error("reset value wrong");
  AST_RESET_OUT: assert property (
    $rose(rst_b) |-> inputPowerMgmtEnable
      && thresholdMvOut == `DPM_THR_RESET_MV)
    else $error("reset controls wrong");

  // tick gating: full rate unless slowed outside the CC and CV phases
  AST_NO_SLOW: assert property (
    (!ctrl_reg.timerHalfRateEnable && timerTick) |=> timerStepEn)
    else $error("timer slowed while half rate off");
  AST_HALF: assert property (
    (slowNow && timerTick && !halfPhase_reg) |=> !timerStepEn)
    else $error("half rate did not drop a tick");
  AST_HALF_PASS: assert property (
    (slowNow && timerTick && halfPhase_reg) |=> timerStepEn)
    else $error("half rate dropped both ticks of a pair");
  AST_CCCV_FULL: assert property (
    (ccCvPhase && timerTick) |=> timerStepEn)
    else $error("timer slowed during constant current or voltage");
  AST_STEP_NEEDS_TICK: assert property (
    !timerTick |=> !timerStepEn)
    else $error("timer step without a tick");

  // safety timer limit and its off code
  AST_TMR_OFF: assert property (
    (ctrl_reg.safetyTimerLimitSelect == TMR_DISABLE) |=> !safetyTimerEnable)
    else $error("timer not disabled by code 11");
  AST_TMR_ON: assert property (
    (ctrl_reg.safetyTimerLimitSelect != TMR_DISABLE) |=> safetyTimerEnable)
    else $error("timer disabled by a running code");
  AST_LIMIT_COPY: assert property (
    safetyTimerLimitSelect == $past(ctrl_reg.safetyTimerLimitSelect))
    else $error("timer limit not passed on");

  // register storage: writes, global reset and holding
  AST_WRITE: assert property (
    (wrThis && !globalRst) |=> ctrl_reg == {$past(regWdata[7:1]), 1'b0})
    else $error("write not stored");
  AST_GLOBAL: assert property (
    globalRst |=> ctrl_reg == `DPM_REG_RESET)
    else $error("global reset did not restore default");
  AST_GLOBAL_OUT: assert property (
    globalRst |=> ##1 (inputPowerMgmtEnable
      && thresholdMvOut == `DPM_THR_RESET_MV))
    else $error("global reset did not restore the controls");
  AST_HOLD: assert property (
    (!wrThis && !globalRst) |=> $stable(ctrl_reg))
    else $error("register changed without a write");

  // read port: content for one cycle when addressed, zero otherwise
  AST_RDATA: assert property (
    (req.rd && hitThis) |=> regRdata == $past(ctrl_reg))
    else $error("read data not the register content");
  AST_RDATA_IDLE: assert property (
    !(req.rd && hitThis) |=> regRdata == 8'h00)
    else $error("read data while not addressed");
  AST_UNUSED: assert property (
    ctrl_reg[0] == 1'b0 && regRdata[0] == 1'b0)
    else $error("unused bit set");

  // main scenarios the bench should reach
  COV_WRITE:     cover property (wrThis);
  COV_GLOBAL:    cover property (globalRst);
  COV_SLOW:      cover property (slowNow && timerTick);
  COV_HALF_PASS: cover property (slowNow && timerTick && halfPhase_reg);
  COV_TOFF:      cover property (!safetyTimerEnable);

endmodule
`default_nettype wire

// [verif/test_charger_input_dpm_timer_regs.sv]
// Purpose: self-checking bench for the power management and timer register
// Assumes: one-cycle strobes, controls settle two edges after a write
// Notes:   bench drives the register port and timer inputs directly
`timescale 1ns/1ps
`default_nettype none
module test_charger_input_dpm_timer_regs;
  import dpm_timer_pkg::*;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         regWr = 1'b0;
  logic         regRd = 1'b0;
  logic         ccCvPhase = 1'b0;
  logic         timerTick = 1'b0;
  logic [7:0]   regAddr = 8'h00;
  logic [7:0]   regWdata = 8'h00;
  logic [7:0]   regRdata;
  logic         inputPowerMgmtEnable;
  logic         timerStepEn;
  logic         safetyTimerEnable;
  logic [15:0]  thresholdMvOut;
  timer_limit_e safetyTimerLimitSelect;
  int           err_count = 0;
  int           n_compared = 0;
  logic [7:0]   v;
  int           cnt;
  logic [7:0]   tbl [4] = '{8'hFF, 8'h01, 8'hA3, 8'h34};

  charger_input_dpm_timer_regs dut_u (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .ccCvPhase(ccCvPhase),
    .timerTick(timerTick), .regRdata(regRdata),
    .inputPowerMgmtEnable(inputPowerMgmtEnable),
    .thresholdMvOut(thresholdMvOut), .timerStepEn(timerStepEn),
    .safetyTimerEnable(safetyTimerEnable),
    .safetyTimerLimitSelect(safetyTimerLimitSelect));

  // free-running clock, 40 ns period
  always #20 clock = ~clock;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write, then wait the two edges the decoded controls need
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 q = regRdata;
  endtask

  // decoded controls and read-back against a register value
  task chk_reg(input logic [7:0] d);
    chk(inputPowerMgmtEnable, !d[7]);
    chk(thresholdMvOut, 16'h1068 + 16'(d[6:4]) * 16'h0064);
    chk(safetyTimerLimitSelect, d[2:1]);
    chk(safetyTimerEnable, d[2:1] != 2'b11);
    rd(8'h0B, v);
    chk(v, d & 8'hFE);
  endtask

  // ticks two cycles apart, counts passed steps and checks them against exp
  task ticks(input logic half, input logic cc, input int exp);
    wr(8'h0B, half ? 8'h0A : 8'h02);
    @(posedge clock);
    ccCvPhase <= cc;
    cnt = 0;
    repeat (4) begin
      @(posedge clock);
      timerTick <= 1'b1;
      @(posedge clock);
      timerTick <= 1'b0;
      #1 cnt += (timerStepEn === 1'b1);
    end
    chk(cnt, exp);
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, far beyond the roughly 80 cycles the tests take
  initial begin
    #100000;
    err_count++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    test_reset;
    test_fields;
    test_unmapped;
    test_global;
    test_timer;
    end_sim;
  end

  // defaults straight after reset release
  task test_reset;
    chk_reg(8'h42);
    $display("test reset done");
  endtask

  // every field written, timer limit through all four codes, bit 0 written as one
  task test_fields;
    foreach (tbl[i]) begin
      wr(8'h0B, tbl[i]);
      chk_reg(tbl[i]);
    end
    $display("test fields done");
  endtask

  // other addresses neither store nor answer; last value is 0x34
  task test_unmapped;
    wr(8'h0C, 8'h00);
    chk_reg(8'h34);
    rd(8'h0C, v);
    chk(v, 8'h00);
    $display("test unmapped done");
  endtask

  // global register reset brings the default back
  task test_global;
    wr(8'h09, 8'h80);
    chk_reg(8'h42);
    $display("test global reset done");
  endtask

  // full rate, full rate inside CC or CV, half rate outside
  task test_timer;
    ticks(1'b0, 1'b0, 4);
    ticks(1'b1, 1'b1, 4);
    ticks(1'b1, 1'b0, 2);
    $display("test timer done");
  endtask
endmodule
`default_nettype wire
